// ===== logic/sfr_fast_read.v
// fast read command path of a serial nor flash, with an apb register port
// assumes spi pins from outside the clock domain, sclk well below clk_in / 4
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "sfr_map.vh"

module sfr_fast_read #(
    parameter MEM_AW = 8 // log2 of backing array size in bytes
) (
    // clock and reset
    input wire CLK_IN,
    input wire RESET_N_IN,
    // apb slave
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [7:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    // serial flash pins
    input wire SPI_CS_N_IN,
    input wire SPI_SCLK_IN,
    input wire [3:0] SPI_IO_IN,
    output reg [3:0] SPI_IO_OUT,
    output reg [3:0] SPI_IO_OE_OUT
);

    // sequencer states
    localparam ST_IDLE = 3'd0;
    localparam ST_CMD = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_MODE = 3'd3;
    localparam ST_DUMMY = 3'd4;
    localparam ST_DATA = 3'd5;
    localparam ST_PARAM = 3'd6;
    localparam ST_IGNORE = 3'd7;

    // opcode accepted in the present mode
    function op_ok;
        input [7:0] op;
        input four_wire_command_mode;
        input qe;
        begin
            if (four_wire_command_mode) begin
                op_ok = (op == `SFR_OP_FAST) || (op == `SFR_OP_SETP);
            end else begin
                case (op)
                    `SFR_OP_FAST, `SFR_OP_FAST4, `SFR_OP_DOUT, `SFR_OP_DOUT4,
                    `SFR_OP_DIO: op_ok = 1'b1;
                    `SFR_OP_QOUT, `SFR_OP_QOUT4: op_ok = qe;
                    default: op_ok = 1'b0;
                endcase
            end
        end
    endfunction

    // lanes carrying read data
    function [2:0] data_lanes;
        input [7:0] op;
        input four_wire_command_mode;
        begin
            if (four_wire_command_mode) begin
                data_lanes = 3'd4;
            end else begin
                case (op)
                    `SFR_OP_DOUT, `SFR_OP_DOUT4, `SFR_OP_DIO: data_lanes = 3'd2;
                    `SFR_OP_QOUT, `SFR_OP_QOUT4: data_lanes = 3'd4;
                    default: data_lanes = 3'd1;
                endcase
            end
        end
    endfunction

    // pin synchronisers, stage one feeds stage two only
    reg cs_s1, cs_s2, cs_s3;
    reg sclk_s1, sclk_s2, sclk_s3;
    reg [3:0] io_s1, io_s2;

    // volatile settings
    reg qe; // quad enable bit
    reg four_wire_command_mode; // four-wire command mode
    reg address_width_mode; // address width mode
    reg [1:0] rp; // dummy-count field
    reg [7:0] ext; // extended address byte
    reg cont; // continuous read armed

    // sequencer
    reg [2:0] state;
    reg [7:0] opcode;
    reg [31:0] shin; // rising-edge input shifter
    reg [5:0] bcnt; // bits taken in this phase
    reg [3:0] dcnt; // dummy clocks seen
    reg [31:0] rd_addr; // next byte to fetch
    reg [7:0] shout; // falling-edge output shifter
    reg [2:0] sh_cnt; // bits sent of current byte

    // backing array and its apb pointer
    reg [7:0] mem [0:(1<<MEM_AW)-1];
    reg [MEM_AW-1:0] mptr;

    // edges seen on the synchronised pins
    wire rise = sclk_s2 & ~sclk_s3;
    wire fall = ~sclk_s2 & sclk_s3;
    wire cs_fall = ~cs_s2 & cs_s3;

    // dummy length in four-wire mode: 2,4,6,8
    wire [3:0] qpi_dummy = {1'b0, rp, 1'b0} + `SFR_DUMMY_QPI_BASE;

    // long address when forced or wide
    wire long_addr = address_width_mode || (!four_wire_command_mode && ((opcode == `SFR_OP_FAST4) ||
        (opcode == `SFR_OP_DOUT4) || (opcode == `SFR_OP_QOUT4)));
    wire [5:0] abits = long_addr ? `SFR_ABITS_LONG : `SFR_ABITS_SHORT;

    // lanes and shifted input for the current phase
    reg [2:0] in_lanes;
    reg [31:0] shin_next;
    always @* begin
        case (state)
            ST_ADDR: in_lanes = four_wire_command_mode ? 3'd4 : ((opcode == `SFR_OP_DIO) ? 3'd2 : 3'd1);
            ST_MODE: in_lanes = `SFR_MODE_LANES;
            ST_CMD, ST_PARAM: in_lanes = four_wire_command_mode ? 3'd4 : 3'd1;
            default: in_lanes = 3'd1;
        endcase
        // msb first on each lane group
        case (in_lanes)
            3'd4: shin_next = {shin[27:0], io_s2};
            3'd2: shin_next = {shin[29:0], io_s2[1:0]};
            default: shin_next = {shin[30:0], io_s2[0]};
        endcase
    end
    wire [5:0] bsum = bcnt + {3'b000, in_lanes};

    // output byte in hand, fetched fresh at each byte boundary
    wire [2:0] out_lanes = data_lanes(opcode, four_wire_command_mode);
    wire [7:0] out_cur = (sh_cnt == 3'd0) ? mem[rd_addr[MEM_AW-1:0]] : shout;

    // synchronisers, plain flops with no reset dependence on pins
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
        end else begin
            cs_s1 <= SPI_CS_N_IN;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            sclk_s1 <= SPI_SCLK_IN;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            io_s1 <= SPI_IO_IN;
            io_s2 <= io_s1;
        end
    end

    // command sequencer plus settings written from either side
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            state <= ST_IDLE;
            opcode <= 8'h00;
            shin <= 32'h0000_0000;
            bcnt <= 6'h00;
            dcnt <= 4'h0;
            rd_addr <= 32'h0000_0000;
            shout <= 8'h00;
            sh_cnt <= 3'd0;
            cont <= 1'b0;
            qe <= 1'b0;
            four_wire_command_mode <= 1'b0;
            address_width_mode <= 1'b0;
            rp <= `SFR_RST_RP;
            ext <= `SFR_RST_EXT;
            SPI_IO_OUT <= 4'h0;
            SPI_IO_OE_OUT <= 4'h0;
        end else begin
            // software settings, taken at the completing apb edge
            if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
                PADDR_IN == `SFR_OFS_CTRL) begin
                qe <= PWDATA_IN[`SFR_CTRL_QE];
                four_wire_command_mode <= PWDATA_IN[`SFR_CTRL_QPI];
                address_width_mode <= PWDATA_IN[`SFR_CTRL_ADS];
                rp <= PWDATA_IN[`SFR_CTRL_RP_HI:`SFR_CTRL_RP_LO];
                ext <= PWDATA_IN[`SFR_CTRL_EXT_HI:`SFR_CTRL_EXT_LO];
            end
            if (cs_s2) begin
                state <= ST_IDLE;
                SPI_IO_OE_OUT <= 4'h0;
            end else if (cs_fall) begin
                bcnt <= 6'h00;
                dcnt <= 4'h0;
                if (cont && !four_wire_command_mode) begin
                    state <= ST_ADDR;
                    opcode <= `SFR_OP_DIO;
                end else begin
                    state <= ST_CMD;
                    opcode <= 8'h00;
                end
            end else if (rise) begin
                shin <= shin_next;
                bcnt <= bsum;
                case (state)
                    ST_CMD: begin
                        if (bsum == `SFR_BYTE_BITS) begin
                            bcnt <= 6'h00;
                            opcode <= shin_next[7:0];
                            if (!op_ok(shin_next[7:0], four_wire_command_mode, qe)) begin
                                // unsupported here: stay silent till deselect
                                state <= ST_IGNORE;
                            end else if (shin_next[7:0] == `SFR_OP_SETP) begin
                                state <= ST_PARAM;
                            end else begin
                                state <= ST_ADDR;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (bsum == abits) begin
                            bcnt <= 6'h00;
                            if (long_addr) begin
                                rd_addr <= shin_next;
                            end else begin
                                rd_addr <= {ext, shin_next[23:0]};
                            end
                            if (opcode == `SFR_OP_DIO && !four_wire_command_mode) begin
                                state <= ST_MODE;
                            end else begin
                                state <= ST_DUMMY;
                            end
                        end
                    end
                    ST_MODE: begin
                        if (bsum == `SFR_BYTE_BITS) begin
                            cont <= (shin_next[5:4] == `SFR_CONT_KEEP);
                            state <= ST_DATA;
                            sh_cnt <= 3'd0;
                        end
                    end
                    ST_DUMMY: begin
                        dcnt <= dcnt + 4'h1;
                        if ((dcnt + 4'h1) == (four_wire_command_mode ? qpi_dummy : `SFR_DUMMY_SPI)) begin
                            state <= ST_DATA;
                            sh_cnt <= 3'd0;
                        end
                    end
                    ST_PARAM: begin
                        if (bsum == `SFR_BYTE_BITS) begin
                            rp <= shin_next[5:4];
                            state <= ST_IGNORE;
                        end
                    end
                    default: begin
                        bcnt <= 6'h00;
                    end
                endcase
            end else if (fall && state == ST_DATA) begin
                // new bits driven on falling edge
                if (sh_cnt == 3'd0) begin
                    rd_addr <= rd_addr + 32'h0000_0001;
                end
                shout <= out_cur << out_lanes;
                sh_cnt <= sh_cnt + out_lanes;
                case (out_lanes)
                    3'd4: begin
                        SPI_IO_OUT <= out_cur[7:4];
                        SPI_IO_OE_OUT <= 4'hF;
                    end
                    3'd2: begin
                        SPI_IO_OUT <= {2'b00, out_cur[7:6]};
                        SPI_IO_OE_OUT <= 4'h3;
                    end
                    default: begin
                        SPI_IO_OUT <= {2'b00, out_cur[7], 1'b0};
                        SPI_IO_OE_OUT <= 4'h2;
                    end
                endcase
            end else if (state != ST_DATA) begin
                SPI_IO_OE_OUT <= 4'h0;
            end
        end
    end

    // backing array load port, pointer auto-advances on data write
    always @(posedge CLK_IN) begin
        if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
            PADDR_IN == `SFR_OFS_MDAT) begin
            mem[mptr] <= PWDATA_IN[7:0];
        end
    end

    // apb slave: one wait state, read data and error from flops
    always @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            mptr <= {MEM_AW{1'b0}};
        end else begin
            PREADY_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
            if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
                PSLVERR_OUT <= 1'b0;
                PRDATA_OUT <= 32'h0000_0000;
                case (PADDR_IN)
                    `SFR_OFS_CTRL: PRDATA_OUT <= {16'h0000, ext, 2'b00, rp, 1'b0,
                        address_width_mode, four_wire_command_mode, qe};
                    `SFR_OFS_STAT: PRDATA_OUT <= {15'h0000, ~cs_s2, opcode,
                        4'h0, state, cont};
                    `SFR_OFS_MPTR: PRDATA_OUT[MEM_AW-1:0] <= mptr;
                    `SFR_OFS_MDAT: PRDATA_OUT[7:0] <= mem[mptr];
                    // unmapped: error, reads zero
                    default: PSLVERR_OUT <= 1'b1;
                endcase
            end else begin
                // error stands only in the ready cycle
                PSLVERR_OUT <= 1'b0;
            end
            // pointer updates at the completing edge
            if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN) begin
                if (PADDR_IN == `SFR_OFS_MPTR) begin
                    mptr <= PWDATA_IN[MEM_AW-1:0];
                end else if (PADDR_IN == `SFR_OFS_MDAT) begin
                    mptr <= mptr + {{(MEM_AW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // sfr_fast_read

// ===== logic/sfr_map.vh
// offsets, fields, opcodes and timing figures of the fast read path
// assumes inclusion by every design file that decodes registers or commands
`ifndef SFR_MAP_VH
`define SFR_MAP_VH

// register byte offsets on the apb slave
`define SFR_OFS_CTRL 8'h00
`define SFR_OFS_STAT 8'h04
`define SFR_OFS_MPTR 8'h08
`define SFR_OFS_MDAT 8'h0C

// control word fields
`define SFR_CTRL_QE 0
`define SFR_CTRL_QPI 1
`define SFR_CTRL_ADS 2
`define SFR_CTRL_RP_LO 4
`define SFR_CTRL_RP_HI 5
`define SFR_CTRL_EXT_LO 8
`define SFR_CTRL_EXT_HI 15

// reset values of the volatile settings
`define SFR_RST_RP 2'h0
`define SFR_RST_EXT 8'h00

// opcodes of the read family
`define SFR_OP_FAST 8'h0B
`define SFR_OP_FAST4 8'h0C
`define SFR_OP_DOUT 8'h3B
`define SFR_OP_DOUT4 8'h3C
`define SFR_OP_QOUT 8'h6B
`define SFR_OP_QOUT4 8'h6C
`define SFR_OP_DIO 8'hBB
`define SFR_OP_SETP 8'hC0

// continuous read select value that skips the next opcode
`define SFR_CONT_KEEP 2'b10

// dummy clocks in single-lane command mode, and base of the four-wire choice
`define SFR_DUMMY_SPI 4'h8
`define SFR_DUMMY_QPI_BASE 4'h2

// address widths and byte length in bits, lanes of the mode byte
`define SFR_ABITS_SHORT 6'h18
`define SFR_ABITS_LONG 6'h20
`define SFR_BYTE_BITS 6'h08
`define SFR_MODE_LANES 3'h2

`endif

// ===== dv/sfr_fast_read_checker.sv
// checker of the fast read path: apb handshake and lane drive timing
// assumes it is bound to sfr_fast_read and the link clock runs well below CLK_IN
`timescale 1ns/1ns
module sfr_fast_read_checker #(
    parameter MEM_AW = 8 // array size, not used by these checks
) (
    // clock and reset
    input wire CLK_IN,
    input wire RESET_N_IN,
    // apb side
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire [7:0] PADDR_IN,
    input wire [31:0] PRDATA_OUT,
    input wire PREADY_OUT,
    input wire PSLVERR_OUT,
    // link side
    input wire SPI_CS_N_IN,
    input wire SPI_SCLK_IN,
    input wire [3:0] SPI_IO_OUT,
    input wire [3:0] SPI_IO_OE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // access phase still waiting for its answer
    wire acc = PSEL_IN && PENABLE_IN && !PREADY_OUT;

    a_ready_wait: assert property (acc |=> PREADY_OUT)
        else $error("ready missing one cycle after access");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held longer than one cycle");
    a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error flag without ready");
    a_unmapped_err: assert property (acc && PADDR_IN > 8'h0C |=>
        PSLVERR_OUT && PRDATA_OUT == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_deselect_quiet: assert property (SPI_CS_N_IN [*6] |-> SPI_IO_OE_OUT == 4'h0)
        else $error("lanes driven while deselected");
    a_shift_on_fall: assert property (!SPI_CS_N_IN && |SPI_IO_OE_OUT && $changed(SPI_IO_OUT)
        |-> !$past(SPI_SCLK_IN, 2) || !$past(SPI_SCLK_IN, 3))
        else $error("lane data changed after a rising link edge");
    a_oe_on_fall: assert property ($rose(|SPI_IO_OE_OUT)
        |-> !$past(SPI_SCLK_IN, 2) || !$past(SPI_SCLK_IN, 3))
        else $error("lane drive began away from a falling link edge");
    a_lane_sets: assert property (SPI_IO_OE_OUT inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("illegal set of driven lanes");

    c_quad: cover property (SPI_IO_OE_OUT == 4'hF);
    c_dual: cover property (SPI_IO_OE_OUT == 4'h3);
    c_refused: cover property (PSLVERR_OUT);
endmodule // sfr_fast_read_checker

bind sfr_fast_read sfr_fast_read_checker #(.MEM_AW(MEM_AW)) u_chk (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .SPI_CS_N_IN(SPI_CS_N_IN), .SPI_SCLK_IN(SPI_SCLK_IN),
    .SPI_IO_OUT(SPI_IO_OUT), .SPI_IO_OE_OUT(SPI_IO_OE_OUT));

// ===== dv/sfr_host_model.sv
// host flash controller model: select, link clock of eight system clocks, lanes
// assumes the bench resolves the lanes and calls the tasks right after a clock edge
`timescale 1ns/1ns
module sfr_host_model (
    // system clock and resolved lanes
    input wire logic clk,
    input wire logic [3:0] io_wire,
    // link drive
    output logic cs_n,
    output logic sclk,
    output logic [3:0] drv,
    output logic [3:0] drv_oe,
    // received bytes
    output logic [7:0] rd_byte,
    output logic rd_stb
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        drv = 4'h0;
        drv_oe = 4'h0;
        rd_byte = 8'h00;
        rd_stb = 1'b0;
    end
    task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] got);
        sclk <= 1'b0;
        drv <= v;
        drv_oe <= oe;
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        got = io_wire; // taken late so the device bit has settled
    endtask
    task automatic send(input logic [31:0] val, input int nbits, input int lanes);
        logic [3:0] g;
        for (int i = nbits - lanes; i >= 0; i -= lanes)
            tick(4'(val >> i) & 4'((1 << lanes) - 1), 4'((1 << lanes) - 1), g);
    endtask
    task automatic idle(input int n);
        logic [3:0] g;
        repeat (n) tick(4'h0, 4'h0, g);
    endtask
    // one byte gathered from the device lanes
    task automatic get(input int lanes);
        logic [3:0] g;
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 8 / lanes; i++) begin
            tick(4'h0, 4'h0, g);
            b = (lanes == 1) ? {b[6:0], g[1]} : (lanes == 2) ? {b[5:0], g[1:0]} : {b[3:0], g};
        end
        rd_byte <= b;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
    endtask
    task automatic start();
        cs_n <= 1'b0;
        @(posedge clk);
    endtask
    task automatic stop();
        cs_n <= 1'b1;
        @(posedge clk);
        sclk <= 1'b0;
        drv_oe <= 4'h0;
        repeat (6) @(posedge clk);
    endtask
endmodule // sfr_host_model

// ===== dv/test_sfr_fast_read.sv
// bench of the fast read path: registers over apb, array fill, read frames
// assumes sfr_host_model as link partner and the checker bound to the design
`timescale 1ns/1ns
`include "sfr_map.vh"
module test_sfr_fast_read;
    logic clk = 1'b0;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    wire [31:0] prdata;
    wire pready, pslverr, cs_n, sclk, h_stb;
    wire [3:0] h_drv, h_oe, d_out, d_oe, lanes;
    wire [7:0] h_byte;
    logic tgl = 1'b0; // floats on lanes nobody drives
    logic oe_seen = 1'b0; // any device drive in this frame
    logic [7:0] mem [0:255];
    logic [7:0] exp_b [$];
    logic [32:0] exp_r [$];
    int miscompares = 0;
    int num_checks = 0;
    integer seed = 32'hf2f3;

    always #10 clk = ~clk;
    always @(posedge clk) tgl <= ~tgl;
    always @(posedge clk) oe_seen <= cs_n ? 1'b0 : (oe_seen | (|d_oe));
    // wire level from every party's enable
    assign lanes = (d_oe & d_out) | (~d_oe & h_oe & h_drv) | (~d_oe & ~h_oe & {4{tgl}});

    sfr_fast_read #(.MEM_AW(8)) dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SPI_CS_N_IN(cs_n),
        .SPI_SCLK_IN(sclk), .SPI_IO_IN(lanes), .SPI_IO_OUT(d_out), .SPI_IO_OE_OUT(d_oe));
    sfr_host_model host (.clk(clk), .io_wire(lanes), .cs_n(cs_n), .sclk(sclk), .drv(h_drv),
        .drv_oe(h_oe), .rd_byte(h_byte), .rd_stb(h_stb));

    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] flash_byte exp %h got %h", e, g);
        end
    endtask
    task automatic cmp_reg(input string n, input logic [32:0] e, input logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // results taken off the queues as they appear
    always @(posedge clk) begin
        if (h_stb === 1'b1) cmp_byte(exp_b.pop_front(), h_byte);
        if (psel && penable && !pwrite && pready === 1'b1)
            cmp_reg("prdata", exp_r.pop_front(), {pslverr, prdata});
    end
    // one apb transfer, waits for ready with no bound of its own
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the watchdog bounds this wait
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_r.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // select, optional opcode, address with random upper bits
    task automatic cmd(input logic [7:0] op, input int cl, input int alen, input int al,
        input logic [7:0] a);
        host.start();
        if (cl > 0) host.send({24'h00_0000, op}, 8, cl);
        host.send({24'($random(seed)), a}, alen, al);
    endtask
    task automatic data(input int dl, input logic [7:0] a, input int n);
        for (int k = 0; k < n; k++) begin
            exp_b.push_back(mem[8'(a + k)]);
            host.get(dl);
        end
        host.stop();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        logic [7:0] a;
        logic [7:0] op_t [0:5];
        op_t = '{8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C};
        rst_n <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`SFR_OFS_CTRL, 33'h0_0000_0000);
        rd(8'h40, 33'h1_0000_0000);
        apb(1'b1, `SFR_OFS_MPTR, 32'h0000_0000);
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($random(seed));
            apb(1'b1, `SFR_OFS_MDAT, {24'h00_0000, mem[i]});
        end
        // pointer wrapped after a full fill; reads leave it alone
        rd(`SFR_OFS_MPTR, 33'h0_0000_0000);
        rd(`SFR_OFS_MDAT, {25'h000_0000, mem[0]});
        // quad output refused while quad enable is clear
        a = 8'($random(seed));
        cmd(8'h6B, 1, 24, 1, a);
        host.idle(10);
        cmp_reg("lane_enable", 33'h0_0000_0000, {32'h0000_0000, oe_seen});
        host.stop();
        apb(1'b1, `SFR_OFS_CTRL, 32'h0000_0001);
        rd(`SFR_OFS_CTRL, 33'h0_0000_0001);
        for (int i = 0; i < 6; i++) begin
            a = 8'($random(seed));
            cmd(op_t[i], 1, op_t[i][0] ? 24 : 32, 1, a);
            host.idle(8);
            data(1 << (i / 2), a, 3);
        end
        apb(1'b1, `SFR_OFS_CTRL, 32'h0000_0005);
        a = 8'($random(seed));
        cmd(8'h0B, 1, 32, 1, a);
        host.idle(8);
        data(1, a, 2);
        apb(1'b1, `SFR_OFS_CTRL, 32'h0000_0001);
        // dual address, continuous mode armed, used once, then left
        a = 8'($random(seed));
        cmd(8'hBB, 1, 24, 2, a);
        host.send({24'h00_0000, 4'h2, 4'($random(seed))}, 8, 2);
        data(2, a, 2);
        a = 8'($random(seed));
        cmd(8'h00, 0, 24, 2, a);
        host.send({24'h00_0000, 4'h2, 4'($random(seed))}, 8, 2);
        data(2, a, 2);
        // still armed: all ones on lane zero for 16 clocks leaves the mode
        host.start();
        host.send(32'h0000_FFFF, 16, 1);
        host.stop();
        a = 8'($random(seed));
        cmd(8'h0B, 1, 24, 1, a);
        host.idle(8);
        data(1, a, 2);
        // four-wire mode: default dummies first, then each field value
        apb(1'b1, `SFR_OFS_CTRL, 32'h0000_0003);
        for (int f = 0; f < 4; f++) begin
            if (f > 0) begin
                host.start();
                host.send({24'h00_0000, 8'hC0}, 8, 4);
                host.send({24'h00_0000, 2'b00, 2'(f), 4'h0}, 8, 4);
                host.stop();
            end
            a = 8'($random(seed));
            cmd(8'h0B, 4, 24, 4, a);
            host.idle(2 * f + 2);
            data(4, a, 2);
        end
        a = 8'($random(seed));
        cmd(8'h0C, 4, 32, 4, a);
        host.idle(10);
        cmp_reg("lane_enable", 33'h0_0000_0000, {32'h0000_0000, oe_seen});
        host.stop();
        complete_run();
    end
    // watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule // test_sfr_fast_read
